// *** include/iwdt_pkg.sv ***
package iwdt_pkg;

	// ==========================================================
	// word format
	localparam int WORD_W      = 24;
	localparam int OPC_LSB     = 16;
	localparam int OPND_W      = 16;
	localparam int HI_ADDR_W   = 7;

	// ==========================================================
	// operand field positions (lsb of each field)
	localparam int F_BASE      = 12;
	localparam int F_SRC       = 8;
	localparam int F_SRCMODE   = 6;
	localparam int F_DST       = 2;
	localparam int F_DSTMODE   = 0;
	localparam int F_FILE_ACC  = 13;
	localparam int F_BYTE      = 14;
	localparam int F_BIT_REG   = 15;
	localparam int F_BIT_FILE  = 14;
	localparam int F_BIT_NUM   = 10;
	localparam int F_LITW      = 4;
	localparam int F_LITF      = 8;
	localparam int F_ALU_LIT   = 6;
	localparam int F_TBL_MODE  = 14;
	localparam int F_TBL_DST   = 4;

	// ==========================================================
	// opcodes
	localparam logic [7:0] OP_NO_OPERATION    = 8'h00;
	localparam logic [7:0] OP_REG_ALU         = 8'h10;
	localparam logic [7:0] OP_REG_SHIFT       = 8'h11;
	localparam logic [7:0] OP_MOVE_DOUBLE_REG = 8'h12;
	localparam logic [7:0] OP_FILE_ALU        = 8'h20;
	localparam logic [7:0] OP_BIT_SET         = 8'h30;
	localparam logic [7:0] OP_BIT_ROTATE      = 8'h31;
	localparam logic [7:0] OP_LIT_MOVE_REG    = 8'h40;
	localparam logic [7:0] OP_LIT_MOVE_FILE   = 8'h41;
	localparam logic [7:0] OP_LIT_ALU         = 8'h50;
	localparam logic [7:0] OP_LIT_ALU_INPLACE = 8'h51;
	localparam logic [7:0] OP_RELATIVE_JUMP   = 8'h60;
	localparam logic [7:0] OP_COND_BRANCH     = 8'h61;
	localparam logic [7:0] OP_SKIP_IF         = 8'h62;
	localparam logic [7:0] OP_INDIRECT_JUMP   = 8'h63;
	localparam logic [7:0] OP_INDIRECT_CALL   = 8'h64;
	localparam logic [7:0] OP_TABLE_READ      = 8'h65;
	localparam logic [7:0] OP_TABLE_WRITE     = 8'h66;
	localparam logic [7:0] OP_SUB_RETURN      = 8'h67;
	localparam logic [7:0] OP_INTERRUPT_EXIT  = 8'h68;
	localparam logic [7:0] OP_ABSOLUTE_JUMP   = 8'h70;
	localparam logic [7:0] OP_ABSOLUTE_CALL   = 8'h71;
	localparam logic [7:0] OP_MOVE_DOUBLE_ABS = 8'h72;

	// ==========================================================
	// cycle counts per instruction
	localparam logic [1:0] CYC_ONE    = 2'd1;
	localparam logic [1:0] CYC_JUMP   = 2'd2;
	localparam logic [1:0] CYC_TABLE  = 2'd2;
	localparam logic [1:0] CYC_DOUBLE = 2'd2;
	localparam logic [1:0] CYC_RETURN = 2'd3;

	localparam logic [1:0] MODE_DIRECT = 2'd0;

	typedef enum logic [2:0] {
		GRP_NONE, GRP_REG, GRP_FILE, GRP_BIT, GRP_LIT_MOVE, GRP_LIT_ALU, GRP_CTRL
	} iwdt_group_e;

	typedef enum logic [2:0] {
		ST_RUN, ST_SECOND, ST_EXTRA, ST_SKIP1, ST_SKIP2
	} iwdt_state_e;

endpackage

// *** design/iwdt_decoder.sv ***
`timescale 1ns/100ps
// What this block does
// - single word is 24 bits, top 8-bit opcode picks type, rest operands
// - exactly three opcodes take two program words, all others one
// - two-word instruction is 48 bits; second word's upper byte is zero
// - a lone second word decodes as no_operation
// - one cycle normally; taken test or one-word pc change adds one idle cycle, two for returns and for skips over two words
// - jumps, indirect calls, table ops and returns take two or three cycles
// - taken skip costs two cycles over one word, three over two words
// - double moves and two-word instructions take exactly two cycles
// - register ops carry base source, second source and destination
// - file ops carry file address and destination file or accumulator
// - bit ops name register or file, bit from literal or base register
// - literal moves load a literal into named register or file
// - literal alu uses base and literal; destination only if different
// - control ops carry a program address or a table mode
// - register fields select one of sixteen working registers
module iwdt_decoder
	import iwdt_pkg::*;
(
	// clock and reset
	input  wire logic               clk_sys,
	input  wire logic               nrst,
	// fetch side
	input  wire logic               fetchValid,
	input  wire logic [23:0]        fetchWord,
	output logic                    fetchReady,
	// test result from datapath
	input  wire logic               condTrue,
	// execute side
	output logic                    execValid_r,
	output logic                    nopCycle_r,
	output logic                    secondWordErr_r,
	output logic [7:0]              opcode_r,
	output iwdt_pkg::iwdt_group_e   group_r,
	output logic [3:0]              baseSourceReg_r,
	output logic [3:0]              secondSourceReg_r,
	output logic [1:0]              secondSourceMode_r,
	output logic [3:0]              destReg_r,
	output logic [1:0]              destMode_r,
	output logic [12:0]             fileAddr_r,
	output logic                    destFileOpAccumulator_r,
	output logic                    byteMode_r,
	output logic                    targetIsFile_r,
	output logic                    bitFromReg_r,
	output logic [3:0]              bitNum_r,
	output logic [15:0]             literal_r,
	output logic [22:0]             progAddr_r,
	output logic [1:0]              tableMode_r
);
	import iwdt_pkg::*;

	// ==========================================================
	// word slicing
	logic [7:0]        opc;
	logic [15:0]       w;
	logic              accept;
	iwdt_state_e       state_r, state_nxt;
	logic [1:0]        extra_r, extra_nxt;
	logic [15:0]       hold_r, hold_nxt;
	logic [7:0]        holdOp_r, holdOp_nxt;

	assign opc = fetchWord[OPC_LSB +: 8];
	assign w   = fetchWord[OPND_W-1:0];
	assign fetchReady = (state_r != ST_EXTRA);
	assign accept = fetchValid && fetchReady;

	function automatic logic isTwoWord(input logic [7:0] op);
		isTwoWord = (op == OP_ABSOLUTE_JUMP) || (op == OP_ABSOLUTE_CALL) ||
			(op == OP_MOVE_DOUBLE_ABS);
	endfunction

	// ==========================================================
	// next values
	logic              execValid_nxt, nopCycle_nxt, secondWordErr_nxt;
	logic [7:0]        opcode_nxt;
	iwdt_group_e       group_nxt;
	logic [3:0]        base_nxt, src_nxt, dst_nxt, bitNum_nxt;
	logic [1:0]        srcMode_nxt, dstMode_nxt, tableMode_nxt;
	logic [12:0]       fileAddr_nxt;
	logic              acc_nxt, byte_nxt, tFile_nxt, bitReg_nxt;
	logic [15:0]       literal_nxt;
	logic [22:0]       progAddr_nxt;
	logic [1:0]        cyc;

	always_comb begin
		state_nxt = state_r;
		group_nxt = group_r;
		{extra_nxt, hold_nxt, holdOp_nxt} = {extra_r, hold_r, holdOp_r};
		{execValid_nxt, nopCycle_nxt, secondWordErr_nxt} = 3'h0;
		{opcode_nxt, bitNum_nxt, literal_nxt} = {opcode_r, bitNum_r, literal_r};
		{base_nxt, src_nxt, srcMode_nxt} = {baseSourceReg_r, secondSourceReg_r, secondSourceMode_r};
		{dst_nxt, dstMode_nxt, fileAddr_nxt} = {destReg_r, destMode_r, fileAddr_r};
		{acc_nxt, byte_nxt} = {destFileOpAccumulator_r, byteMode_r};
		{tFile_nxt, bitReg_nxt} = {targetIsFile_r, bitFromReg_r};
		{progAddr_nxt, tableMode_nxt} = {progAddr_r, tableMode_r};
		cyc = CYC_ONE;
		case (state_r)
			ST_RUN: begin
				if (accept) begin
					opcode_nxt = opc;
					execValid_nxt = 1'b1;
					case (opc)
						OP_REG_ALU, OP_REG_SHIFT, OP_MOVE_DOUBLE_REG: begin
							group_nxt = GRP_REG;
							base_nxt = w[F_BASE +: 4];
							src_nxt = w[F_SRC +: 4];
							srcMode_nxt = w[F_SRCMODE +: 2];
							dst_nxt = w[F_DST +: 4];
							dstMode_nxt = w[F_DSTMODE +: 2];
							if (opc == OP_MOVE_DOUBLE_REG)
								cyc = CYC_DOUBLE;
						end
						OP_FILE_ALU: begin
							group_nxt = GRP_FILE;
							fileAddr_nxt = w[12:0];
							acc_nxt = w[F_FILE_ACC];
							byte_nxt = w[F_BYTE];
						end
						OP_BIT_SET, OP_BIT_ROTATE: begin
							group_nxt = GRP_BIT;
							bitReg_nxt = w[F_BIT_REG];
							tFile_nxt = w[F_BIT_FILE];
							bitNum_nxt = w[F_BIT_NUM +: 4];
							base_nxt = w[F_BIT_NUM +: 4];
							fileAddr_nxt = {3'h0, w[9:0]};
							src_nxt = w[3:0];
							srcMode_nxt = w[5:4];
						end
						OP_LIT_MOVE_REG: begin
							group_nxt = GRP_LIT_MOVE;
							literal_nxt = {4'h0, w[OPND_W-1:F_LITW]};
							dst_nxt = w[3:0];
							tFile_nxt = 1'b0;
						end
						OP_LIT_MOVE_FILE: begin
							group_nxt = GRP_LIT_MOVE;
							literal_nxt = {8'h00, w[OPND_W-1:F_LITF]};
							fileAddr_nxt = {5'h00, w[7:0]};
							tFile_nxt = 1'b1;
						end
						OP_LIT_ALU: begin
							group_nxt = GRP_LIT_ALU;
							base_nxt = w[F_BASE +: 4];
							literal_nxt = {10'h000, w[F_ALU_LIT +: 6]};
							dst_nxt = w[3:0];
							dstMode_nxt = w[5:4];
						end
						OP_LIT_ALU_INPLACE: begin
							group_nxt = GRP_LIT_ALU;
							base_nxt = w[F_BASE +: 4];
							literal_nxt = {4'h0, w[11:0]};
							dst_nxt = w[F_BASE +: 4];
							dstMode_nxt = MODE_DIRECT;
						end
						OP_RELATIVE_JUMP: begin
							group_nxt = GRP_CTRL;
							literal_nxt = w;
							cyc = CYC_JUMP;
						end
						OP_COND_BRANCH: begin
							group_nxt = GRP_CTRL;
							literal_nxt = w;
							if (condTrue)
								cyc = CYC_JUMP;
						end
						OP_SKIP_IF: begin
							group_nxt = GRP_CTRL;
							if (condTrue)
								state_nxt = ST_SKIP1;
						end
						OP_INDIRECT_JUMP, OP_INDIRECT_CALL: begin
							group_nxt = GRP_CTRL;
							src_nxt = w[3:0];
							cyc = CYC_JUMP;
						end
						OP_TABLE_READ, OP_TABLE_WRITE: begin
							group_nxt = GRP_CTRL;
							tableMode_nxt = w[F_TBL_MODE +: 2];
							src_nxt = w[3:0];
							dst_nxt = w[F_TBL_DST +: 4];
							cyc = CYC_TABLE;
						end
						OP_SUB_RETURN, OP_INTERRUPT_EXIT: begin
							group_nxt = GRP_CTRL;
							cyc = CYC_RETURN;
						end
						OP_ABSOLUTE_JUMP, OP_ABSOLUTE_CALL, OP_MOVE_DOUBLE_ABS: begin
							execValid_nxt = 1'b0;
							hold_nxt = w;
							holdOp_nxt = opc;
							state_nxt = ST_SECOND;
						end
						default: begin
							// no_operation, lone second words and unknown codes
							execValid_nxt = 1'b0;
							nopCycle_nxt = 1'b1;
							group_nxt = GRP_NONE;
						end
					endcase
					if (cyc != CYC_ONE) begin
						extra_nxt = cyc - CYC_ONE;
						state_nxt = ST_EXTRA;
					end
				end
			end
			ST_SECOND: begin
				if (accept) begin
					execValid_nxt = 1'b1;
					secondWordErr_nxt = |opc;
					if (holdOp_r == OP_MOVE_DOUBLE_ABS) begin
						group_nxt = GRP_REG;
						fileAddr_nxt = hold_r[12:0];
						dst_nxt = w[3:0];
					end else begin
						group_nxt = GRP_CTRL;
						progAddr_nxt = {w[HI_ADDR_W-1:0], hold_r};
					end
					state_nxt = ST_RUN;
				end
			end
			ST_EXTRA: begin
				nopCycle_nxt = 1'b1;
				extra_nxt = extra_r - 2'd1;
				if (extra_r == 2'd1)
					state_nxt = ST_RUN;
			end
			ST_SKIP1: begin
				if (accept) begin
					nopCycle_nxt = 1'b1;
					state_nxt = isTwoWord(opc) ? ST_SKIP2 : ST_RUN;
				end
			end
			ST_SKIP2: begin
				if (accept) begin
					nopCycle_nxt = 1'b1;
					state_nxt = ST_RUN;
				end
			end
			default: state_nxt = ST_RUN;
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_RUN;
			group_r <= GRP_NONE;
			{extra_r, hold_r, holdOp_r} <= 26'h0000000;
			{execValid_r, nopCycle_r, secondWordErr_r} <= 3'h0;
			{opcode_r, bitNum_r, literal_r} <= 28'h0000000;
			{baseSourceReg_r, secondSourceReg_r, secondSourceMode_r} <= 10'h000;
			{destReg_r, destMode_r, fileAddr_r} <= 19'h00000;
			{destFileOpAccumulator_r, byteMode_r} <= 2'h0;
			{targetIsFile_r, bitFromReg_r} <= 2'h0;
			{progAddr_r, tableMode_r} <= 25'h0000000;
		end else begin
			state_r <= state_nxt;
			group_r <= group_nxt;
			{extra_r, hold_r, holdOp_r} <= {extra_nxt, hold_nxt, holdOp_nxt};
			{execValid_r, nopCycle_r, secondWordErr_r} <= {execValid_nxt, nopCycle_nxt, secondWordErr_nxt};
			{opcode_r, bitNum_r, literal_r} <= {opcode_nxt, bitNum_nxt, literal_nxt};
			{baseSourceReg_r, secondSourceReg_r, secondSourceMode_r} <= {base_nxt, src_nxt, srcMode_nxt};
			{destReg_r, destMode_r, fileAddr_r} <= {dst_nxt, dstMode_nxt, fileAddr_nxt};
			{destFileOpAccumulator_r, byteMode_r} <= {acc_nxt, byte_nxt};
			{targetIsFile_r, bitFromReg_r} <= {tFile_nxt, bitReg_nxt};
			{progAddr_r, tableMode_r} <= {progAddr_nxt, tableMode_nxt};
		end
	end

	// ==========================================================
	// assertions
	logic acceptRun;
	logic [3:0] wBase;
	logic [12:0] wFile;
	assign acceptRun = accept && (state_r == ST_RUN);
	assign wBase = w[F_BASE +: 4];
	assign wFile = w[12:0];

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	property p_lone_second;
		acceptRun && (opc == OP_NO_OPERATION) |=> nopCycle_r && !execValid_r;
	endproperty
	a_lone_second: assert property (p_lone_second) else $error("lone second word not idle");
	property p_two_word;
		acceptRun && isTwoWord(opc) |=> !execValid_r && (state_r == ST_SECOND);
	endproperty
	a_two_word: assert property (p_two_word) else $error("two-word start mishandled");
	property p_second_done;
		(state_r == ST_SECOND) && accept |=> execValid_r && (state_r == ST_RUN);
	endproperty
	a_second_done: assert property (p_second_done) else $error("second word not executed");
	property p_second_zero;
		(state_r == ST_SECOND) && accept |=> secondWordErr_r == ($past(opc) != 8'h00);
	endproperty
	a_second_zero: assert property (p_second_zero) else $error("second word check wrong");
	property p_branch_taken;
		acceptRun && (opc == OP_COND_BRANCH) && condTrue
			|=> execValid_r && !fetchReady ##1 nopCycle_r && fetchReady;
	endproperty
	a_branch_taken: assert property (p_branch_taken) else $error("taken branch not two cycles");
	property p_return;
		acceptRun && (opc == OP_SUB_RETURN || opc == OP_INTERRUPT_EXIT)
			|=> !fetchReady [*2] ##1 fetchReady && nopCycle_r;
	endproperty
	a_return: assert property (p_return) else $error("return not three cycles");
	property p_skip_two;
		(state_r == ST_SKIP1) && accept && isTwoWord(opc) |=> nopCycle_r && (state_r == ST_SKIP2);
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("skip over two words wrong");
	property p_reg_fields;
		acceptRun && (opc == OP_REG_ALU) |=> baseSourceReg_r == $past(wBase) && group_r == GRP_REG;
	endproperty
	a_reg_fields: assert property (p_reg_fields) else $error("base register not decoded");
	property p_file_fields;
		acceptRun && (opc == OP_FILE_ALU) |=> fileAddr_r == $past(wFile);
	endproperty
	a_file_fields: assert property (p_file_fields) else $error("file address not decoded");
	property p_inplace;
		acceptRun && (opc == OP_LIT_ALU_INPLACE) |=> destReg_r == $past(wBase) && destMode_r == MODE_DIRECT;
	endproperty
	a_inplace: assert property (p_inplace) else $error("in-place destination wrong");

	c_two_word: cover property (acceptRun && isTwoWord(opc) ##1 accept);
	c_skip: cover property (acceptRun && (opc == OP_SKIP_IF) && condTrue);
	c_return: cover property (acceptRun && (opc == OP_INTERRUPT_EXIT));
	c_table: cover property (acceptRun && (opc == OP_TABLE_READ));

endmodule

// *** tb/iwdt_fetch_model.sv ***
`timescale 1ns/100ps
module iwdt_fetch_model (
	// clock and reset
	input  wire logic   clk_sys,
	input  wire logic   nrst,
	// decoder fetch port
	input  wire logic   fetchReady,
	output logic        fetchValid,
	output logic [23:0] fetchWord,
	output logic        condTrue
);
	// ==========================================================
	// word queue, entry is {condTrue, word}
	logic [24:0] q[$];
	int          gap;
	int          idle;
	logic        rdySeen;

	initial begin
		fetchValid = 1'b0;
		fetchWord = 24'h000000;
		condTrue = 1'b0;
		gap = 0;
		idle = 0;
		rdySeen = 1'b0;
	end

	// ready settled by mid cycle, avoids edge race
	always @(negedge clk_sys) begin
		rdySeen = fetchReady;
	end

	// ==========================================================
	// offer, hold until taken, then optional stall
	always @(posedge clk_sys) begin
		if (nrst && fetchValid && rdySeen) begin
			void'(q.pop_front());
			idle = gap;
		end
		#1;
		if (nrst && q.size() > 0 && idle == 0) begin
			fetchValid = 1'b1;
			{condTrue, fetchWord} = q[0];
		end else begin
			// released lines move, never keep the old word
			if (idle > 0)
				idle--;
			fetchValid = 1'b0;
			fetchWord = ~fetchWord;
			condTrue = ~condTrue;
		end
	end
endmodule

// *** tb/test_instruction_word_decode_timing.sv ***
`timescale 1ns/100ps
module test_instruction_word_decode_timing;
	import iwdt_pkg::*;

	logic        clk_sys;
	logic        nrst;
	logic        fetchValid, fetchReady, condTrue;
	logic [23:0] fetchWord;
	logic        execValid_r, nopCycle_r, secondWordErr_r, destFileOpAccumulator_r;
	logic        byteMode_r, targetIsFile_r, bitFromReg_r;
	logic [7:0]  opcode_r;
	iwdt_group_e group_r;
	logic [3:0]  baseSourceReg_r, secondSourceReg_r, destReg_r, bitNum_r;
	logic [1:0]  secondSourceMode_r, destMode_r, tableMode_r;
	logic [12:0] fileAddr_r;
	logic [15:0] literal_r;
	logic [22:0] progAddr_r;
	int          err_total;
	int          checks_done;
	string       trace;

	iwdt_decoder dut_u (
		.clk_sys, .nrst, .fetchValid, .fetchWord, .fetchReady, .condTrue, .execValid_r, .nopCycle_r,
		.secondWordErr_r, .opcode_r, .group_r, .baseSourceReg_r, .secondSourceReg_r, .secondSourceMode_r,
		.destReg_r, .destMode_r, .fileAddr_r, .destFileOpAccumulator_r, .byteMode_r, .targetIsFile_r,
		.bitFromReg_r, .bitNum_r, .literal_r, .progAddr_r, .tableMode_r
	);

	iwdt_fetch_model fetch_u (
		.clk_sys, .nrst, .fetchReady, .fetchValid, .fetchWord, .condTrue
	);

	always #2.5 clk_sys = ~clk_sys;

	// ==========================================================
	// per-cycle trace: E execute, R execute with bad word 2, N idle
	always @(posedge clk_sys) begin
		#2;
		if (execValid_r === 1'b1 && secondWordErr_r === 1'b1)
			trace = {trace, "R"};
		else if (execValid_r === 1'b1)
			trace = {trace, "E"};
		else if (nopCycle_r === 1'b1)
			trace = {trace, "N"};
		else
			trace = {trace, "."};
	end

	// ==========================================================
	// helpers
	function automatic string trim(string s, bit dropAll);
		string r;
		int    a;
		int    b;
		r = "";
		a = 0;
		b = s.len() - 1;
		while (a <= b && s.substr(a, a) == ".")
			a++;
		while (b >= a && s.substr(b, b) == ".")
			b--;
		for (int i = a; i <= b; i++)
			if (!(dropAll && s.substr(i, i) == "."))
				r = {r, s.substr(i, i)};
		return r;
	endfunction

	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp=%h got=%h", nm, e, g);
		end
	endtask

	task automatic chkS(string nm, string e, string g);
		checks_done++;
		if (e != g) begin
			err_total++;
			$display("[FAIL] %s exp=%s got=%s", nm, e, g);
		end
	endtask

	task automatic issue(logic [23:0] w, logic c = 1'b0);
		fetch_u.q.push_back({c, w});
	endtask

	task automatic play(bit dropAll, output string s);
		trace = "";
		repeat (40) @(posedge clk_sys);
		#3;
		s = trim(trace, dropAll);
	endtask

	task automatic one(logic [23:0] w);
		string s;
		issue(w);
		play(1'b0, s);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset_values();
		chk("fetchReady", 1, fetchReady);
		chk("execValid", 0, execValid_r);
		chk("group", GRP_NONE, group_r);
		chk("progAddr", 0, progAddr_r);
	endtask

	task automatic t_single_cycle();
		logic [7:0] ops[10] = '{8'h10, 8'h11, 8'h20, 8'h30, 8'h31, 8'h40, 8'h41, 8'h50, 8'h51, 8'h61};
		string      s;
		foreach (ops[i])
			issue({ops[i], 16'h0000});
		issue(24'hFF0000);
		play(1'b0, s);
		chkS("single", "EEEEEEEEEEN", s);
	endtask

	task automatic t_multi_cycle();
		logic [7:0] ops[9] = '{8'h60, 8'h61, 8'h63, 8'h64, 8'h65, 8'h66, 8'h12, 8'h67, 8'h68};
		string      s;
		string      e;
		e = "";
		foreach (ops[i]) begin
			issue({ops[i], 16'h0000}, ops[i] == OP_COND_BRANCH);
			e = {e, (ops[i] >= OP_SUB_RETURN) ? "ENN" : "EN"};
		end
		play(1'b0, s);
		chkS("multi", e, s);
	endtask

	task automatic t_two_word();
		string s;
		issue({OP_MOVE_DOUBLE_ABS, 16'h1ABC});
		issue(24'h00000D);
		play(1'b0, s);
		chkS("double move", "E", s);
		chk("fileAddr", 13'h1ABC, fileAddr_r);
		chk("destReg", 4'hD, destReg_r);
		issue({OP_ABSOLUTE_JUMP, 16'h0000});
		issue(24'h000000);
		issue({OP_ABSOLUTE_CALL, 16'h1234});
		issue(24'h000055);
		issue({OP_REG_ALU, 16'h0000});
		play(1'b0, s);
		chkS("two word", "E.EE", s);
		issue({OP_ABSOLUTE_JUMP, 16'h5678});
		issue(24'h00007F);
		play(1'b0, s);
		chk("progAddr", 23'h7F5678, progAddr_r);
	endtask

	task automatic t_second_word();
		string s;
		issue({OP_ABSOLUTE_JUMP, 16'h0002});
		issue(24'h010003);
		issue(24'h000055);
		issue({OP_REG_ALU, 16'h0000});
		play(1'b0, s);
		chkS("second word", "RNE", s);
	endtask

	task automatic t_skip();
		string s;
		string e;
		issue({OP_SKIP_IF, 16'h0000}, 1'b1);
		issue({OP_REG_ALU, 16'h0000});
		issue({OP_FILE_ALU, 16'h0000});
		e = "ENE";
		for (int op = 8'h70; op <= 8'h72; op++) begin
			issue({OP_SKIP_IF, 16'h0000}, 1'b1);
			issue({op[7:0], 16'h0000});
			issue(24'h000000);
			issue({OP_REG_ALU, 16'h0000});
			e = {e, "ENNE"};
		end
		issue({OP_SKIP_IF, 16'h0000}, 1'b0);
		issue({OP_REG_ALU, 16'h0000});
		play(1'b0, s);
		chkS("skip", {e, "EE"}, s);
	endtask

	task automatic t_slow_fetch();
		string s;
		fetch_u.gap = 3;
		issue({OP_SUB_RETURN, 16'h0000});
		issue({OP_REG_ALU, 16'h0000});
		issue({OP_ABSOLUTE_JUMP, 16'h0000});
		issue(24'h000001);
		play(1'b1, s);
		fetch_u.gap = 0;
		chkS("slow fetch", "ENNEE", s);
	endtask

	task automatic t_operand_fields();
		one({OP_REG_ALU, 16'hF0C9});
		chk("group", GRP_REG, group_r);
		chk("baseSrc", 4'hF, baseSourceReg_r);
		chk("secondSrc", 4'h0, secondSourceReg_r);
		chk("srcMode", 2'h3, secondSourceMode_r);
		chk("dest", 4'h2, destReg_r);
		chk("destMode", 2'h1, destMode_r);
		one({OP_FILE_ALU, 16'h7FFF});
		chk("fileAddr", 13'h1FFF, fileAddr_r);
		chk("toAcc", 1'b1, destFileOpAccumulator_r);
		chk("byte", 1'b1, byteMode_r);
		one({OP_FILE_ALU, 16'h1234});
		chk("toAcc", 1'b0, destFileOpAccumulator_r);
		one({OP_BIT_SET, 16'h66A5});
		chk("isFile", 1'b1, targetIsFile_r);
		chk("bitFromReg", 1'b0, bitFromReg_r);
		chk("bitNum", 4'h9, bitNum_r);
		chk("fileAddr", 13'h02A5, fileAddr_r);
		one({OP_BIT_ROTATE, 16'h9400});
		chk("bitFromReg", 1'b1, bitFromReg_r);
		chk("isFile", 1'b0, targetIsFile_r);
		one({OP_LIT_MOVE_REG, 16'hABCE});
		chk("literal", 16'h0ABC, literal_r);
		chk("dest", 4'hE, destReg_r);
		one({OP_LIT_MOVE_FILE, 16'h5A3C});
		chk("literal", 16'h005A, literal_r);
		chk("fileAddr", 13'h003C, fileAddr_r);
		one({OP_LIT_ALU, 16'h3FC7});
		chk("base", 4'h3, baseSourceReg_r);
		chk("literal", 16'h003F, literal_r);
		chk("dest", 4'h7, destReg_r);
		one({OP_LIT_ALU_INPLACE, 16'h9123});
		chk("literal", 16'h0123, literal_r);
		chk("dest", 4'h9, destReg_r);
		one({OP_TABLE_READ, 16'hC0A5});
		chk("tableMode", 2'h3, tableMode_r);
		chk("opcode", 8'h65, opcode_r);
	endtask

	// ==========================================================
	// run control
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		#(5 * 3000);
		$display("[FAIL] watchdog exp=done got=hang");
		err_total++;
		tally_and_finish();
	end

	initial begin
		clk_sys = 1'b0;
		nrst = 1'b0;
		err_total = 0;
		checks_done = 0;
		trace = "";
		repeat (12) @(posedge clk_sys);
		#1;
		t_reset_values();
		nrst = 1'b1;
		t_single_cycle();
		t_multi_cycle();
		t_two_word();
		t_second_word();
		t_skip();
		t_slow_fetch();
		t_operand_fields();
		tally_and_finish();
	end
endmodule
